// file: rtl/ctec_top.v
// charge time edge control: control register, edge sources, edge state
`timescale 1ns/1ns
// Notes on behaviour
// - first input sensitivity bit: one edge, zero level
// - first polarity: one rising, zero falling
// - four-bit selector picks first edge source
// - second input sensitivity bit: edge or level
// - second polarity: one rising, zero falling
// - second selector; code 1100 picks bus clock
// - first status set by edge, writable
// - second status set by edge, writable
// - edge capture, current, trigger and delay pulse work only while enable bit set
// - stop-in-idle halts unit during idle mode
// - delay pulse only when delay generation enabled
// - edge enable passes edges, else blocks
// - order enable: second waits for first
// - discharge bit grounds current source output
// - trigger output only while trigger bit set
// - six-bit trim is signed adjustment
// - zero trim means nominal current
// - range codes: 01 x1,10 x10,11 x100,00 x1000
// - clear, set, invert aliases at 4,8,c
// - unimplemented bits read zero
`include "ctec_map.vh"
module ctec_top #(
    parameter SRC_N = 16
) (
    input wire ref_clk_i,
    input wire rstn_i,
    input wire [`CTEC_ADDR_W-1:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    input wire idle_i,
    input wire [SRC_N-1:0] first_src_i,
    input wire [SRC_N-1:0] second_src_i,
    input wire bus_clk_div_i,
    output wire unit_active_o,
    output wire current_on_o,
    output wire source_ground_o,
    output wire trigger_o,
    output wire delay_pulse_o,
    output wire signed [5:0] trim_o,
    output wire trim_nominal_o,
    output reg [3:0] range_onehot_o
);
// ****************************************
// input synchronisers
// ****************************************
// every source is a pin or a foreign event, so each passes two flops
reg [SRC_N-1:0] s1_meta_reg;
reg [SRC_N-1:0] s1_sync_reg;
reg [SRC_N-1:0] s2_meta_reg;
reg [SRC_N-1:0] s2_sync_reg;
reg idle_meta_reg;
reg idle_sync_reg;
wire [SRC_N-1:0] s2_eff;
genvar gi;

generate
    for (gi = 0; gi < SRC_N; gi = gi + 1) begin : g_src
        // bus clock source arrives as a divided level, treated like any pin
        if (gi == `CTEC_SRC_BUSCLK) begin : g_bclk
            assign s2_eff[gi] = bus_clk_div_i;
        end else begin : g_pin
            assign s2_eff[gi] = second_src_i[gi];
        end

        always @(posedge ref_clk_i) begin
            if (!rstn_i) begin
                s1_meta_reg[gi] <= 1'b0;
                s1_sync_reg[gi] <= 1'b0;
                s2_meta_reg[gi] <= 1'b0;
                s2_sync_reg[gi] <= 1'b0;
            end else begin
                s1_meta_reg[gi] <= first_src_i[gi];
                s1_sync_reg[gi] <= s1_meta_reg[gi];
                s2_meta_reg[gi] <= s2_eff[gi];
                s2_sync_reg[gi] <= s2_meta_reg[gi];
            end
        end
    end
endgenerate

// idle mode request from the power controller, also asynchronous here
always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
        idle_meta_reg <= 1'b0;
        idle_sync_reg <= 1'b0;
    end else begin
        idle_meta_reg <= idle_i;
        idle_sync_reg <= idle_meta_reg;
    end
end

// ****************************************
// control register fields
// ****************************************
// field views keep the bit positions in one place
reg [31:0] ctrl_reg;
reg [31:0] ctrl_next;
reg [31:0] sw_next;

// first edge input
wire first_edge_sensitivity;
wire first_edge_polarity;
wire [3:0] first_edge_source;
wire first_edge_status;

// second edge input
wire second_edge_sensitivity;
wire second_edge_polarity;
wire [3:0] second_edge_source;
wire second_edge_status;

// unit and edge handling
wire unit_enable;
wire stop_in_idle;
wire delay_generation_enable;
wire edge_pass_enable;
wire edge_order_enable;

// analog controls
wire source_discharge_control;
wire trigger_output_enable;
wire [5:0] current_trim;
wire [1:0] current_range;

assign first_edge_sensitivity = ctrl_reg[`CTEC_E1_SENS];
assign first_edge_polarity = ctrl_reg[`CTEC_E1_POL];
assign first_edge_source = ctrl_reg[`CTEC_E1_SRC_HI:`CTEC_E1_SRC_LO];
assign first_edge_status = ctrl_reg[`CTEC_E1_STAT];

assign second_edge_sensitivity = ctrl_reg[`CTEC_E2_SENS];
assign second_edge_polarity = ctrl_reg[`CTEC_E2_POL];
assign second_edge_source = ctrl_reg[`CTEC_E2_SRC_HI:`CTEC_E2_SRC_LO];
assign second_edge_status = ctrl_reg[`CTEC_E2_STAT];

assign unit_enable = ctrl_reg[`CTEC_ON];
assign stop_in_idle = ctrl_reg[`CTEC_SIDL];
assign delay_generation_enable = ctrl_reg[`CTEC_DGEN];
assign edge_pass_enable = ctrl_reg[`CTEC_EDGE_PASS_ENABLE];
assign edge_order_enable = ctrl_reg[`CTEC_SEQEN];

assign source_discharge_control = ctrl_reg[`CTEC_DISCH];
assign trigger_output_enable = ctrl_reg[`CTEC_TRIG];
assign current_trim = ctrl_reg[`CTEC_TRIM_HI:`CTEC_TRIM_LO];
assign current_range = ctrl_reg[`CTEC_RNG_HI:`CTEC_RNG_LO];

// ****************************************
// unit activity
// ****************************************
wire idle_stop;
wire run;

// stop-in-idle only acts once the synchronised idle level is seen
assign idle_stop = stop_in_idle & idle_sync_reg;
assign run = unit_enable & ~idle_stop;

// ****************************************
// edge detection
// ****************************************
// edges are taken from the raw selected line, so a polarity write
// cannot fake one; a source switch can, so switch while edges are blocked
reg e1_prev_reg;
reg e2_prev_reg;
wire e1_raw;
wire e1_rise;
wire e1_fall;
wire e1_edge;
wire e1_level;
wire e1_event;
wire e1_hit;
wire e2_raw;
wire e2_rise;
wire e2_fall;
wire e2_edge;
wire e2_level;
wire e2_event;
wire e2_hit;
wire e2_order_ok;

// first input
assign e1_raw = s1_sync_reg[first_edge_source];
assign e1_rise = e1_raw & ~e1_prev_reg;
assign e1_fall = ~e1_raw & e1_prev_reg;
assign e1_edge = first_edge_polarity ? e1_rise : e1_fall;
assign e1_level = e1_raw ~^ first_edge_polarity;
assign e1_event = first_edge_sensitivity ? e1_edge : e1_level;
assign e1_hit = run & edge_pass_enable & e1_event;

// second input: the order gate waits for the first status
assign e2_raw = s2_sync_reg[second_edge_source];
assign e2_rise = e2_raw & ~e2_prev_reg;
assign e2_fall = ~e2_raw & e2_prev_reg;
assign e2_edge = second_edge_polarity ? e2_rise : e2_fall;
assign e2_level = e2_raw ~^ second_edge_polarity;
assign e2_event = second_edge_sensitivity ? e2_edge : e2_level;
assign e2_order_ok = ~edge_order_enable | first_edge_status;
assign e2_hit = run & edge_pass_enable & e2_order_ok & e2_event;

// previous raw lines are tracked even while blocked, so enabling cannot fake an edge
always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
        e1_prev_reg <= 1'b0;
        e2_prev_reg <= 1'b0;
    end else begin
        e1_prev_reg <= e1_raw;
        e2_prev_reg <= e2_raw;
    end
end

// ****************************************
// register writes and aliases
// ****************************************
// an alias write acts on the bits written as one, the rest keep their value
always @* begin
    sw_next = ctrl_reg;
    if (wr_i) begin
        case (addr_i)
            `CTEC_CTRL_ADDR: begin
                sw_next = wdata_i;
            end
            `CTEC_CLR_ADDR: begin
                sw_next = ctrl_reg & ~wdata_i;
            end
            `CTEC_SET_ADDR: begin
                sw_next = ctrl_reg | wdata_i;
            end
            `CTEC_INV_ADDR: begin
                sw_next = ctrl_reg ^ wdata_i;
            end
            default: begin
                sw_next = ctrl_reg;
            end
        endcase
    end
end

always @* begin
    ctrl_next = sw_next;
    // hardware set wins over a software clear in the same cycle
    if (e1_hit) begin
        ctrl_next[`CTEC_E1_STAT] = 1'b1;
    end
    if (e2_hit) begin
        ctrl_next[`CTEC_E2_STAT] = 1'b1;
    end
    ctrl_next = ctrl_next & `CTEC_CTRL_WMASK;
end

// status bits keep their value until software clears them
always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
        ctrl_reg <= `CTEC_CTRL_RESET;
    end else begin
        ctrl_reg <= ctrl_next;
    end
end

// ****************************************
// read back
// ****************************************
// read data are registered and stand for exactly one cycle
wire [15:0] readback_hi;
wire [15:0] readback_lo;
wire [31:0] readback_word;

// unimplemented positions are built in as zeros
assign readback_hi = {
    first_edge_sensitivity,
    first_edge_polarity,
    first_edge_source,
    second_edge_status,
    first_edge_status,
    second_edge_sensitivity,
    second_edge_polarity,
    second_edge_source,
    2'h0
};

assign readback_lo = {
    unit_enable,
    1'b0,
    stop_in_idle,
    delay_generation_enable,
    edge_pass_enable,
    edge_order_enable,
    source_discharge_control,
    trigger_output_enable,
    current_trim,
    current_range
};

assign readback_word = {readback_hi, readback_lo};

always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
        rdata_o <= `CTEC_RDATA_IDLE;
    end else if (rd_i && (addr_i == `CTEC_CTRL_ADDR)) begin
        rdata_o <= readback_word;
    end else begin
        // aliases and unmapped addresses read as zero, so does an idle bus
        rdata_o <= `CTEC_RDATA_IDLE;
    end
end

// ****************************************
// delay pulse
// ****************************************
reg pulse_reg;
wire pulse_next;

// high from the first edge until the second edge status appears
// next-state status bits are used so the pulse lines up with the status
assign pulse_next = run & delay_generation_enable & ctrl_next[`CTEC_E1_STAT] &
    ~ctrl_next[`CTEC_E2_STAT];

always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
        pulse_reg <= 1'b0;
    end else begin
        pulse_reg <= pulse_next;
    end
end

// ****************************************
// analog outputs
// ****************************************
wire one_state;

// current flows while exactly one edge state is set
assign one_state = first_edge_status ^ second_edge_status;
assign current_on_o = run & one_state & ~source_discharge_control;

assign unit_active_o = run;
assign source_ground_o = source_discharge_control;
assign trigger_o = run & trigger_output_enable;
assign delay_pulse_o = pulse_reg;
assign trim_o = current_trim;
assign trim_nominal_o = (current_trim == `CTEC_TRIM_ZERO);

// ****************************************
// current range
// ****************************************
// one-hot select for the analog range switches
always @* begin
    case (current_range)
        `CTEC_RNG_X1: begin
            range_onehot_o = 4'h1;
        end
        `CTEC_RNG_X10: begin
            range_onehot_o = 4'h2;
        end
        `CTEC_RNG_X100: begin
            range_onehot_o = 4'h4;
        end
        default: begin
            // code 00, the thousand-times range
            range_onehot_o = 4'h8;
        end
    endcase
end
endmodule

// file: rtl/ctec_map.vh
// register map, field positions and codes of the charge time edge control block
`ifndef CTEC_MAP_VH
`define CTEC_MAP_VH
// ****************************************
// register addresses
// ****************************************
`define CTEC_ADDR_W 16
`define CTEC_CTRL_ADDR 16'ha200
`define CTEC_CLR_ADDR 16'ha204
`define CTEC_SET_ADDR 16'ha208
`define CTEC_INV_ADDR 16'ha20c
`define CTEC_CTRL_RESET 32'h00000000
`define CTEC_RDATA_IDLE 32'h00000000
`define CTEC_TRIM_ZERO 6'h00
// bits 17-16 and 14 read as zero
`define CTEC_CTRL_WMASK 32'hfffcbfff
// ****************************************
// field positions
// ****************************************
`define CTEC_E1_SENS 31
`define CTEC_E1_POL 30
`define CTEC_E1_SRC_HI 29
`define CTEC_E1_SRC_LO 26
`define CTEC_E2_STAT 25
`define CTEC_E1_STAT 24
`define CTEC_E2_SENS 23
`define CTEC_E2_POL 22
`define CTEC_E2_SRC_HI 21
`define CTEC_E2_SRC_LO 18
`define CTEC_ON 15
`define CTEC_SIDL 13
`define CTEC_DGEN 12
`define CTEC_EDGE_PASS_ENABLE 11
`define CTEC_SEQEN 10
`define CTEC_DISCH 9
`define CTEC_TRIG 8
`define CTEC_TRIM_HI 7
`define CTEC_TRIM_LO 2
`define CTEC_RNG_HI 1
`define CTEC_RNG_LO 0
// ****************************************
// codes
// ****************************************
`define CTEC_RNG_X1 2'h1
`define CTEC_RNG_X10 2'h2
`define CTEC_RNG_X100 2'h3
`define CTEC_RNG_X1000 2'h0
`define CTEC_SRC_BUSCLK 4'hc
`define CTEC_SRC_CMP2 4'he
`endif

// file: testbench/ctec_sva.sv
// checker on the ports of the edge control block
`timescale 1ns/1ns
module ctec_sva (
    input wire ref_clk_i,
    input wire rstn_i,
    input wire [15:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [31:0] rdata_o,
    input wire unit_active_o,
    input wire current_on_o,
    input wire source_ground_o,
    input wire trigger_o,
    input wire signed [5:0] trim_o,
    input wire trim_nominal_o,
    input wire [3:0] range_onehot_o
);
    wire cw = wr_i && addr_i == 16'ha200;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    gnd_write_a: assert property (cw |=> source_ground_o == $past(wdata_i[9]))
        else $error("ground");
    trig_write_a: assert property (cw |=> trigger_o == ($past(wdata_i[8]) && unit_active_o))
        else $error("trigger");
    rng_write_a: assert property (cw |=> range_onehot_o == 4'h1 << ($past(wdata_i[1:0]) + 2'h3))
        else $error("range");
    trim_write_a: assert property (cw |=> trim_o == $past(wdata_i[7:2]) && trim_nominal_o == !trim_o)
        else $error("trim");
    unit_off_a: assert property (cw && !wdata_i[15] |=> !unit_active_o)
        else $error("enable");
    disch_cur_a: assert property (source_ground_o |-> !current_on_o)
        else $error("discharge");
    rsv_bits_a: assert property ((rdata_o & 32'h00034000) == 32'h0)
        else $error("reserved");
    rd_only_a: assert property (rdata_o != 32'h0 |-> $past(rd_i) && $past(addr_i) == 16'ha200)
        else $error("read data");
endmodule

// file: testbench/ctec_src_model.sv
// far side: the selected source lines follow a level, the others churn
`timescale 1ns/1ns
module ctec_src_model (
    input wire ref_clk_i,
    input wire [3:0] code1_i,
    input wire lvl1_i,
    input wire lvl2_i,
    output reg [15:0] first_src_o = 16'h0,
    output reg [15:0] second_src_o = 16'h0,
    output reg bus_clk_div_o = 1'b0
);
    reg [15:0] churn_reg = 16'h5a5a;
    always @(posedge ref_clk_i) begin
        churn_reg <= ~churn_reg;
        bus_clk_div_o <= churn_reg[0];
        first_src_o <= churn_reg & ~(16'h1 << code1_i) | {15'h0, lvl1_i} << code1_i;
        second_src_o <= {churn_reg[15], lvl2_i, churn_reg[13:0]};
    end
endmodule

// file: testbench/ctec_top_tb.sv
// self-checking bench of the charge time edge control block
`timescale 1ns/1ns
module ctec_top_tb;
    reg ref_clk_i = 1'b0;
    reg rstn_i = 1'b0;
    reg [15:0] addr_i = 16'h0;
    reg [31:0] wdata_i = 32'h0;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg idle_i = 1'b0;
    reg [3:0] c1 = 4'h0;
    reg lvl1 = 1'b0;
    reg lvl2 = 1'b0;
    reg rd_q = 1'b0;
    reg [31:0] m = 32'h0;
    reg [31:0] d;
    reg [15:0] k;
    reg [31:0] q[$];
    integer errors = 0;
    integer check_count = 0;
    integer cyc = 0;
    integer pulses = 0;
    wire [31:0] rdata_o;
    wire [15:0] first_src_i, second_src_i;
    wire bus_clk_div_i, unit_active_o, current_on_o, source_ground_o, trigger_o, delay_pulse_o, trim_nominal_o;
    wire signed [5:0] trim_o;
    wire [3:0] range_onehot_o;
    ctec_top i_dut (.*);
    ctec_src_model i_src (.ref_clk_i(ref_clk_i), .code1_i(c1), .lvl1_i(lvl1), .lvl2_i(lvl2),
        .first_src_o(first_src_i), .second_src_o(second_src_i), .bus_clk_div_o(bus_clk_div_i));
    // ****
    // bus cycles and comparisons
    // ****
    task bus(input w, input [15:0] a, input [31:0] e);
        begin
            @(posedge ref_clk_i);
            addr_i <= a;
            wdata_i <= e;
            wr_i <= w;
            rd_i <= !w;
            if (!w) q.push_back(e);
            @(posedge ref_clk_i);
            wr_i <= 1'b0;
            rd_i <= 1'b0;
        end
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("ERROR %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d errors %0d", check_count, errors);
            if (errors == 0 && check_count > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task settle(input integer n);
        begin
            repeat (n) @(posedge ref_clk_i);
            @(negedge ref_clk_i);
        end
    endtask
    always @(posedge ref_clk_i) begin
        rd_q <= rd_i;
        cyc = cyc + 1;
        if (cyc == 3000) begin
            errors = errors + 1;
            finish_test;
        end
    end
    always @(negedge ref_clk_i) begin
        if (rd_q) chk("rdata", q.pop_front(), rdata_o);
        if (delay_pulse_o === 1'b1) pulses = pulses + 1;
    end
    initial begin
        forever #20 ref_clk_i = !ref_clk_i;
    end
    initial begin
        d = $urandom(32'hce083f34);
        repeat (4) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        bus(0, 16'ha200, 32'h0);
        bus(0, 16'ha210, 32'h0);
        repeat (4) begin
            m = $urandom & 32'hfffc3fff;
            bus(1, 16'ha200, m);
            bus(0, 16'ha200, m);
        end
        for (k = 16'h1; k < 16'h4; k = k + 16'h1) begin
            d = $urandom & 32'hfffc3fff;
            m = k == 16'h1 ? m & ~d : k == 16'h2 ? m | d : m ^ d;
            bus(1, 16'ha200 + (k << 2), d);
            bus(0, 16'ha200, m);
        end
        bus(0, 16'ha208, 32'h0);
        c1 = $urandom;
        lvl2 <= 1'b1;
        m = 32'h40789c01 | {2'h0, c1, 26'h0};
        bus(1, 16'ha200, m);
        settle(6);
        bus(0, 16'ha200, m);
        lvl1 <= 1'b1;
        settle(6);
        bus(0, 16'ha200, m | 32'h03000000);
        chk("pulse", 32'h1, pulses);
        lvl2 <= 1'b0;
        m = m & ~32'h03000800;
        bus(1, 16'ha204, 32'h00000800);
        bus(1, 16'ha204, 32'h03000000);
        settle(6);
        bus(0, 16'ha200, m);
        m = 32'h80788801 | {2'h0, c1, 26'h0};
        bus(1, 16'ha200, m);
        settle(6);
        bus(0, 16'ha200, m);
        lvl1 <= 1'b0;
        settle(6);
        bus(0, 16'ha200, m | 32'h01000000);
        settle(0);
        chk("current", 32'h1, {31'h0, current_on_o});
        bus(1, 16'ha208, 32'h00002200);
        idle_i <= 1'b1;
        settle(4);
        chk("current", 32'h0, {31'h0, current_on_o});
        chk("active", 32'h0, {31'h0, unit_active_o});
        bus(1, 16'ha204, 32'h00002000);
        settle(1);
        chk("active", 32'h1, {31'h0, unit_active_o});
        chk("pulse", 32'h1, pulses);
        finish_test;
    end
endmodule
bind ctec_top ctec_sva i_sva (.*);
